// ===== pkg/byte_move_defines.svh
// Purpose: Opcodes, field positions and cycle counts for the byte move and product unit.
// Assumes: 8-bit data, 16-bit code and external addresses.
// Notes: Definitions only.
`ifndef BYTE_MOVE_DEFINES_SVH
`define BYTE_MOVE_DEFINES_SVH
`define OP_STORE_ACC 8'hf5
`define OP_STORE_REG_HI 5'h11
`define OP_COPY_MEM 8'h85
`define OP_TABLE_PTR 8'h93
`define OP_TABLE_PC 8'h83
`define OP_XWR_PTR 8'hf0
`define OP_XWR_REG_HI 7'h79
`define OP_XRD_PTR 8'he0
`define OP_XRD_REG_HI 7'h71
`define OP_PRODUCT 8'ha4
`define CYC_ONE 3'h1
`define CYC_TWO 3'h2
`define CYC_FOUR 3'h4
`endif

// ===== pkg/byte_move_pkg.sv
// Purpose: Types shared by the byte move and product unit.
// Assumes: Nothing beyond the defines header.
// Notes: Structs carry grouped request and memory signals.
package byte_move_pkg;
    typedef enum logic [2:0] {
        ST_FETCH = 3'b000,
        ST_OPND1 = 3'b001,
        ST_OPND2 = 3'b010,
        ST_EXEC = 3'b011,
        ST_DONE = 3'b100
    } exec_state_t;
    typedef struct packed {
        logic [7:0] wr_addr;
        logic [7:0] wr_data;
        logic wr_en;
        logic [7:0] rd_addr;
    } idata_req_t;
    typedef struct packed {
        logic [7:0] addr_hi;
        logic [7:0] addr_lo;
        logic [7:0] wr_data;
        logic code_rd;
        logic xdata_rd;
        logic xdata_wr;
    } ext_bus_t;
endpackage : byte_move_pkg

// ===== design/bank_register_file.sv
// Purpose: Eight bank registers with a registered read port.
// Assumes: One write and one read per clock.
// Notes: Read data lags the address by one clock.
`timescale 1ns/100ps
module bank_register_file #(
    parameter int DEPTH = 8,
    parameter int WIDTH = 8
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // Write port
    input wire logic wr_en,
    input wire logic [$clog2(DEPTH)-1:0] wr_sel,
    input wire logic [WIDTH-1:0] wr_data,
    // Read port
    input wire logic [$clog2(DEPTH)-1:0] rd_sel,
    output logic [WIDTH-1:0] rd_data
);
    logic [WIDTH-1:0] mem [DEPTH];
    always_ff @(posedge clk_sys)
    begin
        if (wr_en)
        begin
            mem[wr_sel] <= wr_data;
        end
    end
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rd_data <= '0;
        end
        else
        begin
            rd_data <= (wr_en && wr_sel == rd_sel) ? wr_data : mem[rd_sel];
        end
    end
endmodule : bank_register_file

// ===== design/byte_move_and_multiply_exec.sv
// Purpose: Executes direct stores, memory copies, code table reads, external transfers, product.
// Assumes: Code bytes arrive one clock after code address; internal and external reads likewise.
// Notes: One state step per machine cycle.
// How it works
// - Opcode f5 plus address stores accumulator there, two bytes, no flags.
// - Opcodes 10001rrr plus address copy that bank register into the address.
// - Opcode 85, source then destination byte, copies source to destination.
// - Opcode 93 loads accumulator from code at accumulator plus pointer16.
// - Opcode 83 increments program counter, then reads code at accumulator plus it.
// - Code table reads drive sum high byte upper, low byte lower port.
// - Opcode f0 writes accumulator to external memory at pointer16.
// - Pointer16 external accesses put its high byte upper, low byte lower.
// - Opcodes f2/f3 write accumulator externally, bank register 0/1 on lower port.
// - Register-addressed external accesses leave the upper port holding its value.
// - Opcode e0 reads external memory at pointer16 into accumulator.
// - Opcodes e2/e3 read external memory at bank register 0/1 into accumulator.
// - Opcode a4 multiplies accumulator by multiplier register, low to accumulator.
// - Product clears carry; product_high_flag set when high byte nonzero.
`timescale 1ns/100ps
`include "byte_move_defines.svh"
module byte_move_and_multiply_exec
    import byte_move_pkg::*;
(
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // Code memory
    input wire logic [7:0] code_data,
    output logic [15:0] code_addr,
    // Internal data memory
    input wire logic [7:0] idata_rd_data,
    output idata_req_t idata,
    // External bus ports
    input wire logic [7:0] xdata_rd_data,
    output ext_bus_t ext,
    // Core state
    input wire logic [15:0] pointer16,
    input wire logic [7:0] mult_reg_in,
    output logic [7:0] acc,
    output logic [7:0] mult_reg,
    output logic carry,
    output logic product_high_flag,
    output logic [15:0] pc,
    output logic instr_done,
    // Bank register preload
    input wire logic bank_wr_en,
    input wire logic [2:0] bank_wr_sel,
    input wire logic [7:0] bank_wr_data
);
    ////////////////////////////////////////////////////////////////////////
    exec_state_t state, next_state;
    logic [7:0] opcode, next_opcode;
    logic [7:0] opnd, next_opnd;
    logic [2:0] cyc, next_cyc;
    logic [15:0] next_pc, next_code_addr;
    logic [7:0] next_acc, next_mult_reg;
    logic next_carry, next_flag;
    logic [7:0] upper_port, next_upper_port;
    ext_bus_t next_ext;
    idata_req_t next_idata;
    logic [7:0] bank_rd;
    logic [15:0] product;
    logic [2:0] bank_sel;

    function automatic logic [2:0] cycles_of(input logic [7:0] op);
        if (op == `OP_STORE_ACC)
            cycles_of = `CYC_ONE;
        else if (op == `OP_PRODUCT)
            cycles_of = `CYC_FOUR;
        else
            cycles_of = `CYC_TWO;
    endfunction : cycles_of

    function automatic logic [1:0] operand_count(input logic [7:0] op);
        if (op == `OP_COPY_MEM)
            operand_count = 2'h2;
        else if (op == `OP_STORE_ACC || op[7:3] == `OP_STORE_REG_HI)
            operand_count = 2'h1;
        else
            operand_count = 2'h0;
    endfunction : operand_count

    bank_register_file #(.DEPTH(8), .WIDTH(8)) u_bank (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .wr_en(bank_wr_en),
        .wr_sel(bank_wr_sel),
        .wr_data(bank_wr_data),
        .rd_sel(bank_sel),
        .rd_data(bank_rd)
    );

    assign product = acc * mult_reg;
    assign bank_sel = (next_opcode[7:1] == `OP_XWR_REG_HI || next_opcode[7:1] == `OP_XRD_REG_HI)
        ? {2'h0, next_opcode[0]} : next_opcode[2:0];
    assign instr_done = (state == ST_DONE);

    ////////////////////////////////////////////////////////////////////////
    always_comb
    begin
        next_state = state;
        next_opcode = opcode;
        next_opnd = opnd;
        next_cyc = cyc;
        next_pc = pc;
        next_code_addr = code_addr;
        next_acc = acc;
        next_mult_reg = mult_reg;
        next_carry = carry;
        next_flag = product_high_flag;
        next_upper_port = upper_port;
        next_ext = '0;
        next_ext.addr_hi = upper_port;
        next_ext.addr_lo = ext.addr_lo;
        next_idata = '0;
        next_idata.rd_addr = idata.rd_addr;
        unique case (state)
            ST_FETCH:
            begin
                next_opcode = code_data;
                next_cyc = cycles_of(code_data);
                next_pc = pc + 16'h0001;
                next_code_addr = pc + 16'h0001;
                if (operand_count(code_data) != 2'h0)
                    next_state = ST_OPND1;
                else
                    next_state = ST_EXEC;
                if (code_data == `OP_TABLE_PTR)
                begin
                    next_code_addr = acc + pointer16;
                    next_ext.addr_hi = next_code_addr[15:8];
                    next_ext.addr_lo = next_code_addr[7:0];
                    next_ext.code_rd = 1'b1;
                end
                else if (code_data == `OP_TABLE_PC)
                begin
                    next_code_addr = acc + next_pc;
                    next_ext.addr_hi = next_code_addr[15:8];
                    next_ext.addr_lo = next_code_addr[7:0];
                    next_ext.code_rd = 1'b1;
                end
                else if (code_data == `OP_XWR_PTR || code_data == `OP_XRD_PTR)
                begin
                    next_ext.addr_hi = pointer16[15:8];
                    next_ext.addr_lo = pointer16[7:0];
                    next_upper_port = pointer16[15:8];
                    next_ext.wr_data = acc;
                    next_ext.xdata_wr = code_data == `OP_XWR_PTR;
                    next_ext.xdata_rd = code_data == `OP_XRD_PTR;
                end
                else if (code_data == `OP_PRODUCT)
                begin
                    next_mult_reg = mult_reg_in;
                end
            end
            ST_OPND1:
            begin
                next_opnd = code_data;
                next_pc = pc + 16'h0001;
                next_code_addr = pc + 16'h0001;
                next_state = ST_EXEC;
                if (opcode == `OP_COPY_MEM)
                begin
                    next_idata.rd_addr = code_data;
                    next_state = ST_OPND2;
                end
                else if (opcode == `OP_STORE_ACC)
                begin
                    next_idata.wr_addr = code_data;
                    next_idata.wr_data = acc;
                    next_idata.wr_en = 1'b1;
                    next_state = ST_DONE;
                end
            end
            ST_OPND2:
            begin
                next_pc = pc + 16'h0001;
                next_code_addr = pc + 16'h0001;
                next_idata.wr_addr = code_data;
                next_idata.wr_data = idata_rd_data;
                next_idata.wr_en = 1'b1;
                next_state = ST_DONE;
            end
            ST_EXEC:
            begin
                next_cyc = cyc - 3'h1;
                if (opcode[7:1] == `OP_XWR_REG_HI || opcode[7:1] == `OP_XRD_REG_HI)
                begin
                    next_ext.addr_lo = bank_rd;
                    next_ext.addr_hi = upper_port;
                    next_ext.wr_data = acc;
                    next_ext.xdata_wr = (cyc == `CYC_TWO) && opcode[7:1] == `OP_XWR_REG_HI;
                    next_ext.xdata_rd = (cyc == `CYC_TWO) && opcode[7:1] == `OP_XRD_REG_HI;
                end
                if (cyc == `CYC_ONE)
                begin
                    next_state = ST_DONE;
                    if (opcode[7:3] == `OP_STORE_REG_HI)
                    begin
                        next_idata.wr_addr = opnd;
                        next_idata.wr_data = bank_rd;
                        next_idata.wr_en = 1'b1;
                    end
                    else if (opcode == `OP_TABLE_PTR || opcode == `OP_TABLE_PC)
                        next_acc = code_data;
                    else if (opcode == `OP_XRD_PTR || opcode[7:1] == `OP_XRD_REG_HI)
                        next_acc = xdata_rd_data;
                    else if (opcode == `OP_PRODUCT)
                    begin
                        next_acc = product[7:0];
                        next_mult_reg = product[15:8];
                        next_carry = 1'b0;
                        next_flag = product[15:8] != 8'h00;
                    end
                end
            end
            ST_DONE:
            begin
                next_code_addr = pc;
                next_state = ST_FETCH;
            end
            default:
            begin
                next_state = ST_FETCH;
            end
        endcase
    end

    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state <= ST_FETCH;
            opcode <= 8'h00;
            opnd <= 8'h00;
            cyc <= 3'h0;
            pc <= 16'h0000;
            code_addr <= 16'h0000;
            acc <= 8'h00;
            mult_reg <= 8'h00;
            carry <= 1'b0;
            product_high_flag <= 1'b0;
            upper_port <= 8'h00;
            ext <= '0;
            idata <= '0;
        end
        else
        begin
            state <= next_state;
            opcode <= next_opcode;
            opnd <= next_opnd;
            cyc <= next_cyc;
            pc <= next_pc;
            code_addr <= next_code_addr;
            acc <= next_acc;
            mult_reg <= next_mult_reg;
            carry <= next_carry;
            product_high_flag <= next_flag;
            upper_port <= next_upper_port;
            ext <= next_ext;
            idata <= next_idata;
        end
    end
endmodule : byte_move_and_multiply_exec

// ===== bench/byte_move_properties.sv
// Purpose: Timing and result checks for the byte move and product unit.
// Assumes: Opcode is taken in the cycle after instr_done, or first after reset.
// Notes: Counts cycles from each opcode fetch.
`timescale 1ns/100ps
module byte_move_properties
    import byte_move_pkg::*;
(
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // Watched ports
    input wire logic [7:0] code_data,
    input wire idata_req_t idata,
    input wire ext_bus_t ext,
    input wire logic [15:0] pointer16,
    input wire logic [7:0] acc,
    input wire logic [7:0] mult_reg,
    input wire logic carry,
    input wire logic product_high_flag,
    input wire logic instr_done
);
    logic fetch_now, next_fetch_now;
    logic [7:0] op, next_op;
    logic [3:0] cnt, next_cnt;
    always_comb
    begin
        next_fetch_now = instr_done;
        next_op = fetch_now ? code_data : op;
        next_cnt = fetch_now ? 4'h1 : cnt + 4'h1;
    end
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            fetch_now <= 1'b1;
            op <= 8'h00;
            cnt <= 4'h0;
        end
        else
        begin
            fetch_now <= next_fetch_now;
            op <= next_op;
            cnt <= next_cnt;
        end
    end
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    sequence product_end;
        instr_done && op == 8'ha4;
    endsequence
    a_product_flags: assert property (
        product_end |-> !carry && product_high_flag == (mult_reg != 8'h00))
        else $error("product flags wrong");
    a_product_len: assert property (
        product_end |-> cnt == 4'h5) else $error("product length wrong");
    a_store_len: assert property (
        instr_done && op == 8'hf5 |-> cnt == 4'h2) else $error("store length wrong");
    a_two_cycle_len: assert property (
        instr_done && op inside {8'h93, 8'h83, 8'hf0, 8'hf2, 8'hf3, 8'he0, 8'he2, 8'he3}
        |-> cnt == 4'h3) else $error("two cycle length wrong");
    a_store_data: assert property (
        idata.wr_en && op == 8'hf5 |-> idata.wr_data == acc) else $error("store data wrong");
    a_wr_pulse: assert property (
        ext.xdata_wr |=> !ext.xdata_wr) else $error("write strobe too long");
    a_pointer_addr: assert property (
        (ext.xdata_wr || ext.xdata_rd) && op inside {8'hf0, 8'he0}
        |-> {ext.addr_hi, ext.addr_lo} == pointer16) else $error("pointer address wrong");
    a_upper_kept: assert property (
        !fetch_now && op inside {8'he2, 8'he3, 8'hf2, 8'hf3} |-> $stable(ext.addr_hi))
        else $error("upper port changed");
    a_table_addr: assert property (
        ext.code_rd && op == 8'h93 |-> {ext.addr_hi, ext.addr_lo} == pointer16 + {8'h00, acc})
        else $error("table address wrong");
endmodule : byte_move_properties
bind byte_move_and_multiply_exec byte_move_properties chk_u (.clk_sys, .rst_n, .code_data,
    .idata, .ext, .pointer16, .acc, .mult_reg, .carry, .product_high_flag, .instr_done);

// ===== bench/ext_memory_model.sv
// Purpose: Code, internal data and off-chip data memories for the unit.
// Assumes: Each read answers from the address that the unit holds in its register.
// Notes: Contents start at zero.
`timescale 1ns/100ps
module ext_memory_model
    import byte_move_pkg::*;
(
    // Clock
    input wire logic clk_sys,
    // Requests
    input wire logic [15:0] code_addr,
    input wire idata_req_t idata,
    input wire ext_bus_t ext,
    // Answers
    output logic [7:0] code_data,
    output logic [7:0] idata_rd_data,
    output logic [7:0] xdata_rd_data
);
    logic [7:0] rom [0:65535];
    logic [7:0] imem [0:255];
    logic [7:0] xmem [0:65535];
    initial
    begin
        for (int i = 0; i < 65536; i++)
        begin
            rom[i] = 8'h00;
            xmem[i] = 8'h00;
            imem[i[7:0]] = 8'h00;
        end
    end
    assign code_data = rom[code_addr];
    assign idata_rd_data = imem[idata.rd_addr];
    assign xdata_rd_data = xmem[{ext.addr_hi, ext.addr_lo}];
    always @(posedge clk_sys)
    begin
        if (idata.wr_en)
            imem[idata.wr_addr] <= idata.wr_data;
        if (ext.xdata_wr)
            xmem[{ext.addr_hi, ext.addr_lo}] <= ext.wr_data;
    end
endmodule : ext_memory_model

// ===== bench/byte_move_and_multiply_exec_tb.sv
// Purpose: Runs a short program through the unit and checks each result.
// Assumes: Memory model answers one clock late.
// Notes: Each check follows the instruction's done pulse.
`timescale 1ns/100ps
module byte_move_and_multiply_exec_tb
    import byte_move_pkg::*;
;
    logic clk_sys, rst_n, carry, product_high_flag, instr_done, bank_wr_en;
    logic [7:0] code_data, idata_rd_data, xdata_rd_data, mult_reg_in, acc, mult_reg, bank_wr_data;
    logic [15:0] code_addr, pointer16, pc, wr_seen, rd_seen, tab_seen;
    logic [2:0] bank_wr_sel;
    idata_req_t idata;
    ext_bus_t ext;
    int error_cnt, checks_done;
    logic [7:0] prog [0:15] = '{8'h93, 8'hf5, 8'h40, 8'h85, 8'h40, 8'h41, 8'h8b, 8'h42,
        8'hf0, 8'he2, 8'hf3, 8'he0, 8'h83, 8'ha4, 8'he0, 8'ha4};
    always #20 clk_sys = ~clk_sys;
    byte_move_and_multiply_exec dut_u (.clk_sys(clk_sys), .rst_n(rst_n),
        .code_data(code_data), .code_addr(code_addr), .idata_rd_data(idata_rd_data),
        .idata(idata), .xdata_rd_data(xdata_rd_data), .ext(ext), .pointer16(pointer16),
        .mult_reg_in(mult_reg_in), .acc(acc), .mult_reg(mult_reg), .carry(carry),
        .product_high_flag(product_high_flag), .pc(pc), .instr_done(instr_done),
        .bank_wr_en(bank_wr_en), .bank_wr_sel(bank_wr_sel), .bank_wr_data(bank_wr_data));
    ext_memory_model mem_u (.clk_sys(clk_sys), .code_addr(code_addr), .idata(idata),
        .ext(ext), .code_data(code_data), .idata_rd_data(idata_rd_data),
        .xdata_rd_data(xdata_rd_data));
    always @(posedge clk_sys)
    begin
        if (ext.xdata_wr) wr_seen <= {ext.addr_hi, ext.addr_lo};
        if (ext.xdata_rd) rd_seen <= {ext.addr_hi, ext.addr_lo};
        if (ext.code_rd) tab_seen <= {ext.addr_hi, ext.addr_lo};
    end
    ////////////////////////////////////////////////////////////////////////////////
    task report_and_stop;
        $display("checks %0d errors %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : report_and_stop
    task chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        checks_done++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    // Waits for the done pulse, then steps into the next fetch cycle.
    task wait_done;
        int n;
        #1;
        n = 0;
        while (instr_done !== 1'b1 && n < 40)
        begin
            @(posedge clk_sys);
            #1;
            n++;
        end
        if (instr_done !== 1'b1)
        begin
            error_cnt++;
            $display("ERROR instr_done expected 1 seen %b", instr_done);
            report_and_stop();
        end
        else
        begin
            @(posedge clk_sys);
            #1;
        end
    endtask : wait_done
    task table_ptr_read;
        wait_done();
        chk("acc", 16'h003a, {8'h00, acc});
        chk("table addr", 16'h0100, tab_seen);
    endtask : table_ptr_read
    task direct_stores;
        wait_done();
        chk("imem 40", 16'h003a, {8'h00, mem_u.imem[8'h40]});
        chk("pc", 16'h0003, pc);
        wait_done();
        chk("imem 41", 16'h003a, {8'h00, mem_u.imem[8'h41]});
        chk("pc", 16'h0006, pc);
        wait_done();
        chk("imem 42", 16'h005c, {8'h00, mem_u.imem[8'h42]});
        chk("pc", 16'h0008, pc);
    endtask : direct_stores
    task external_moves;
        wait_done();
        chk("wr addr", 16'h0100, wr_seen);
        chk("xmem 0100", 16'h003a, {8'h00, mem_u.xmem[16'h0100]});
        wait_done();
        chk("rd addr", 16'h0110, rd_seen);
        chk("acc", 16'h0007, {8'h00, acc});
        wait_done();
        chk("wr addr", 16'h0120, wr_seen);
        chk("xmem 0120", 16'h0007, {8'h00, mem_u.xmem[16'h0120]});
    endtask : external_moves
    task ptr_read;
        wait_done();
        chk("acc", 16'h003a, {8'h00, acc});
    endtask : ptr_read
    task table_pc_read;
        wait_done();
        chk("acc", 16'h00c8, {8'h00, acc});
        chk("pc", 16'h000d, pc);
        chk("table addr", 16'h0047, tab_seen);
    endtask : table_pc_read
    task product(input logic [7:0] lo, input logic [7:0] hi, input logic ov);
        wait_done();
        chk("acc", {8'h00, lo}, {8'h00, acc});
        chk("mult_reg", {8'h00, hi}, {8'h00, mult_reg});
        chk("carry", 16'h0000, {15'h0000, carry});
        chk("flag", {15'h0000, ov}, {15'h0000, product_high_flag});
    endtask : product
    ////////////////////////////////////////////////////////////////////////////////
    initial
    begin
        clk_sys = 1'b0;
        rst_n = 1'b0;
        pointer16 = 16'h0100;
        mult_reg_in = 8'h02;
        bank_wr_en = 1'b0;
        bank_wr_sel = 3'h0;
        bank_wr_data = 8'h00;
        error_cnt = 0;
        checks_done = 0;
        #1;
        for (int i = 0; i < 16; i++)
            mem_u.rom[i] = prog[i];
        mem_u.rom[16'h0100] = 8'h3a;
        mem_u.rom[16'h0047] = 8'hc8;
        mem_u.xmem[16'h0110] = 8'h07;
        repeat (2) @(posedge clk_sys);
        rst_n <= 1'b1;
        bank_wr_en <= 1'b1;
        bank_wr_data <= 8'h10;
        @(posedge clk_sys);
        bank_wr_sel <= 3'h1;
        bank_wr_data <= 8'h20;
        @(posedge clk_sys);
        bank_wr_sel <= 3'h3;
        bank_wr_data <= 8'h5c;
        @(posedge clk_sys);
        bank_wr_en <= 1'b0;
        table_ptr_read();
        direct_stores();
        external_moves();
        ptr_read();
        table_pc_read();
        product(8'h90, 8'h01, 1'b1);
        @(posedge clk_sys);
        mult_reg_in <= 8'h03;
        ptr_read();
        product(8'hae, 8'h00, 1'b0);
        report_and_stop();
    end
endmodule : byte_move_and_multiply_exec_tb
